// >>> inc/reset_source_pkg.sv
// constants for the reset source controller
package reset_source_pkg;

    localparam int unsigned CLK_FREQ_HZ          = 50_000_000;
    // reset processing interval after the last source releases
    localparam int unsigned PROCESS_TIME_NS      = 2000;
    localparam int unsigned PROCESS_CYCLES       =
        (PROCESS_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    // oscillation stabilisation interval after release
    localparam int unsigned STAB_TIME_NS         = 4000;
    localparam int unsigned STAB_CYCLES          =
        (STAB_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    // least low time of the external pin, kept by the driver
    localparam int unsigned EXT_MIN_LOW_NS       = 10_000;
    localparam int unsigned EXT_MIN_LOW_CYCLES   =
        (EXT_MIN_LOW_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

    localparam int unsigned CNT_W                = 10;
    localparam int unsigned NUM_SOURCES          = 4;
    localparam logic [15:0] RESET_VECTOR_ADDR    = 16'h0000;

    // source bit positions in the cause vector
    localparam int unsigned SRC_EXT              = 0;
    localparam int unsigned SRC_WDT              = 1;
    localparam int unsigned SRC_POC              = 2;
    localparam int unsigned SRC_LVD              = 3;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_PROCESS,
        ST_STABILISE,
        ST_RUN
    } seq_state_e;

endpackage

// >>> hdl/reset_cycle_counter.sv
// down counter used for the fixed reset intervals
`timescale 1ns/1ps
module reset_cycle_counter
    import reset_source_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // control
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_val_i,
    // status
    output logic                  done_o
);

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= '0;
        end
        else if (load_i)
        begin
            cnt_q <= load_val_i;
        end
        else if (cnt_q != '0)
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // no term from load_i: the parent builds load_i from done_o
    assign done_o = (cnt_q == '0);

endmodule

// >>> hdl/reset_source_control.sv
// reset source combiner and release sequencer
//
// Overview of operation
// - any of four sources raises reset
// - every reset fetches vector at 0000H/0001H
// - pins float during reset, one pin low
// - external reset follows pin, releases on high
// - watchdog reset releases itself automatically
// - detector reset releases once supply recovers
// - oscillators stop, external clocks ignored
// - stop state kept while reset input
`timescale 1ns/1ps
module reset_source_control
    import reset_source_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // reset sources
    input  wire logic        ext_reset_n_i,
    input  wire logic        wdt_overflow_i,
    input  wire logic        power_on_clear_detector_i,
    input  wire logic        low_voltage_detector_i,
    // low-power state
    input  wire logic        stop_mode_i,
    // system reset and clocking
    output logic             sys_reset_n_o,
    output logic             osc_enable_o,
    output logic             ext_clk_valid_o,
    output logic             use_internal_hs_clk_o,
    output logic             stop_hold_o,
    // pins
    output logic             pins_hiz_o,
    output logic             reset_low_output_pin_o,
    output logic             reset_low_output_pin_oe_o,
    // program start
    output logic             fetch_vector_o,
    output logic [15:0]      vector_addr_o,
    output logic [3:0]       reset_cause_o
);

    seq_state_e        state_q;
    logic              wdt_hold_q;
    logic              any_src;
    logic              cnt_load;
    logic [CNT_W-1:0]  cnt_val;
    logic              cnt_done;
    logic [3:0]        cause_d;

    // watchdog pulse caught until the sequencer is in ST_RESET
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wdt_hold_q <= 1'b0;
        end
        else if (wdt_overflow_i)
        begin
            wdt_hold_q <= 1'b1;
        end
        else if (state_q == ST_RESET)
        begin
            wdt_hold_q <= 1'b0;
        end
    end

    assign cause_d[SRC_EXT] = !ext_reset_n_i;
    assign cause_d[SRC_WDT] = wdt_overflow_i | wdt_hold_q;
    assign cause_d[SRC_POC] = power_on_clear_detector_i;
    assign cause_d[SRC_LVD] = low_voltage_detector_i;
    assign any_src          = |cause_d;

    assign cnt_load = (state_q == ST_RESET && !any_src)
                   || (state_q == ST_PROCESS && cnt_done && !any_src);
    assign cnt_val  = (state_q == ST_RESET) ? CNT_W'(PROCESS_CYCLES)
                                            : CNT_W'(STAB_CYCLES);

    reset_cycle_counter u_counter (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .load_i     (cnt_load),
        .load_val_i (cnt_val),
        .done_o     (cnt_done)
    );

    // release sequencing
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= ST_RESET;
        end
        else if (any_src)
        begin
            state_q <= ST_RESET;
        end
        else
        begin
            case (state_q)
                ST_RESET:     state_q <= ST_PROCESS;
                ST_PROCESS:   if (cnt_done) state_q <= ST_STABILISE;
                ST_STABILISE: if (cnt_done) state_q <= ST_RUN;
                ST_RUN:       state_q <= ST_RUN;
                default:      state_q <= ST_RESET;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sys_reset_n_o             <= 1'b0;
            osc_enable_o              <= 1'b0;
            ext_clk_valid_o           <= 1'b0;
            use_internal_hs_clk_o     <= 1'b1;
            stop_hold_o               <= 1'b0;
            pins_hiz_o                <= 1'b1;
            reset_low_output_pin_o    <= 1'b0;
            reset_low_output_pin_oe_o <= 1'b1;
            fetch_vector_o            <= 1'b0;
            vector_addr_o             <= RESET_VECTOR_ADDR;
        end
        else
        begin
            sys_reset_n_o          <= !any_src && state_q == ST_RUN;
            osc_enable_o           <= !any_src && state_q != ST_RESET;
            ext_clk_valid_o        <= !any_src && state_q == ST_RUN;
            use_internal_hs_clk_o  <= 1'b1;
            stop_hold_o            <= any_src && stop_mode_i;
            pins_hiz_o             <= any_src || state_q != ST_RUN;
            reset_low_output_pin_o <= 1'b0;
            reset_low_output_pin_oe_o <= any_src || state_q != ST_RUN;
            fetch_vector_o         <= !any_src && state_q == ST_STABILISE
                                      && cnt_done;
            vector_addr_o          <= RESET_VECTOR_ADDR;
        end
    end

    // cause of the last reset, latched while reset is active
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            reset_cause_o <= '0;
        end
        else if (any_src)
        begin
            reset_cause_o <= (state_q == ST_RESET) ? (reset_cause_o | cause_d)
                                                   : cause_d;
        end
    end

    // assertions
    property p_src_resets;
        @(posedge clk_i) disable iff (!rstn_i)
        any_src |=> !sys_reset_n_o && pins_hiz_o && !osc_enable_o;
    endproperty
    a_src_resets: assert property (p_src_resets)
        else $error("source did not force reset");

    property p_ext_pin;
        @(posedge clk_i) disable iff (!rstn_i)
        !ext_reset_n_i |=> state_q == ST_RESET;
    endproperty
    a_ext_pin: assert property (p_ext_pin)
        else $error("external pin low did not hold reset");

    property p_wdt_self;
        @(posedge clk_i) disable iff (!rstn_i)
        (wdt_overflow_i ##1 (!wdt_overflow_i && ext_reset_n_i
            && !power_on_clear_detector_i && !low_voltage_detector_i)[*2])
            |=> state_q == ST_PROCESS;
    endproperty
    a_wdt_self: assert property (p_wdt_self)
        else $error("watchdog reset did not release");

    property p_det_release;
        @(posedge clk_i) disable iff (!rstn_i)
        ($fell(low_voltage_detector_i) || $fell(power_on_clear_detector_i))
            && !any_src |=> state_q == ST_PROCESS;
    endproperty
    a_det_release: assert property (p_det_release)
        else $error("detector reset did not release");

    property p_pin_low;
        @(posedge clk_i) disable iff (!rstn_i)
        pins_hiz_o |-> reset_low_output_pin_oe_o && !reset_low_output_pin_o;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("designated pin not driven low");

    property p_run_no_hiz;
        @(posedge clk_i) disable iff (!rstn_i)
        sys_reset_n_o |-> !pins_hiz_o && ext_clk_valid_o;
    endproperty
    a_run_no_hiz: assert property (p_run_no_hiz)
        else $error("pins floating after release");

    property p_vector;
        @(posedge clk_i) disable iff (!rstn_i)
        fetch_vector_o && !any_src
            |-> vector_addr_o == RESET_VECTOR_ADDR ##1 sys_reset_n_o;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector fetch wrong");

    property p_stop_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        any_src && stop_mode_i |=> stop_hold_o;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop state not held");

    property p_osc_stop;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(osc_enable_o) |-> $past(state_q) == ST_RESET || !sys_reset_n_o;
    endproperty
    a_osc_stop: assert property (p_osc_stop)
        else $error("oscillator started while running");

    property p_hold_interval;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(sys_reset_n_o) |-> $past(fetch_vector_o);
    endproperty
    a_hold_interval: assert property (p_hold_interval)
        else $error("release without processing interval");

    c_ext:  cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(ext_reset_n_i));
    c_wdt:  cover property (@(posedge clk_i) disable iff (!rstn_i) wdt_overflow_i);
    c_run:  cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(sys_reset_n_o));
    c_stop: cover property (@(posedge clk_i) disable iff (!rstn_i) stop_hold_o);

endmodule

// >>> sim/reset_source_driver.sv
// external reset driver and supply detector model
`timescale 1ns/1ps
module reset_source_driver
    import reset_source_pkg::*;
#(
    parameter logic [15:0] POC_MV = 16'h0640,
    parameter logic [15:0] LVD_MV = 16'h0a8c
)
(
    // clock
    input  wire logic        clk_i,
    // commands
    input  wire logic        ext_req_i,
    input  wire logic [15:0] supply_mv_i,
    // sources
    output logic             ext_reset_n_o,
    output logic             poc_o,
    output logic             lvd_o
);
    int unsigned low_cnt = 0;

    initial ext_reset_n_o = 1'b1;

    // pin stays low at least the minimum time
    always @(posedge clk_i)
    begin
        if (ext_req_i || (!ext_reset_n_o && low_cnt < EXT_MIN_LOW_CYCLES))
        begin
            ext_reset_n_o <= 1'b0;
            low_cnt       <= low_cnt + 1;
        end
        else
        begin
            ext_reset_n_o <= 1'b1;
            low_cnt       <= 0;
        end
    end

    // detectors flag supply below threshold
    assign poc_o = supply_mv_i < POC_MV;
    assign lvd_o = supply_mv_i < LVD_MV;
endmodule

// >>> sim/tb_top.sv
// testbench for the reset source controller
`timescale 1ns/1ps
module tb_top;
    import reset_source_pkg::*;

    logic        clk_i       = 1'b0;
    logic        rstn_i      = 1'b0;
    logic        ext_req     = 1'b0;
    logic [15:0] supply_mv   = 16'h0000;
    logic        wdt_ovf     = 1'b0;
    logic        stop_mode   = 1'b0;
    logic        ext_n;
    logic        power_on_clear_detector;
    logic        lvd;
    logic        sys_n;
    logic        osc_en;
    logic        clk_valid;
    logic        use_hs;
    logic        stop_hold;
    logic        hiz;
    logic        low_pin;
    logic        low_oe;
    logic        fetch;
    logic [15:0] vec;
    logic [3:0]  cause;
    int          bad_count   = 0;
    int          comparisons = 0;

    always #10 clk_i = ~clk_i;

    reset_source_driver reset_source_driver_inst (.clk_i(clk_i), .ext_req_i(ext_req),
        .supply_mv_i(supply_mv), .ext_reset_n_o(ext_n), .poc_o(power_on_clear_detector), .lvd_o(lvd));

    reset_source_control reset_source_control_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .ext_reset_n_i(ext_n), .wdt_overflow_i(wdt_ovf), .power_on_clear_detector_i(power_on_clear_detector),
        .low_voltage_detector_i(lvd), .stop_mode_i(stop_mode), .sys_reset_n_o(sys_n),
        .osc_enable_o(osc_en), .ext_clk_valid_o(clk_valid), .use_internal_hs_clk_o(use_hs),
        .stop_hold_o(stop_hold), .pins_hiz_o(hiz), .reset_low_output_pin_o(low_pin),
        .reset_low_output_pin_oe_o(low_oe), .fetch_vector_o(fetch), .vector_addr_o(vec),
        .reset_cause_o(cause));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic check_held(input logic stop);
        // a watchdog reset starts processing on its third edge
        cycles(2);
        check(sys_n, 1'b0);
        check({osc_en, clk_valid}, 2'b00);
        check({hiz, low_pin, low_oe}, 3'b101);
        check(stop_hold, stop);
    endtask

    task automatic wait_release(input logic [3:0] exp_cause);
        int n;
        n = 0;
        while (fetch !== 1'b1 && n < 1000)
        begin
            cycles(1);
            n++;
        end
        check(n >= PROCESS_CYCLES + STAB_CYCLES, 1'b1);
        check({hiz, low_oe, sys_n}, 3'b110);
        check(vec, RESET_VECTOR_ADDR);
        cycles(1);
        check({fetch, sys_n, hiz, low_oe}, 4'h4);
        check({osc_en, clk_valid, use_hs}, 3'b111);
        check(cause, exp_cause);
    endtask

    task automatic t_supply();
        check_held(1'b0);
        @(posedge clk_i);
        supply_mv <= 16'h07d0;
        check_held(1'b0);
        @(posedge clk_i);
        supply_mv <= 16'h0ce4;
        wait_release(4'hc);
        $display("test supply done");
    endtask

    task automatic t_ext();
        @(posedge clk_i);
        ext_req   <= 1'b1;
        stop_mode <= 1'b1;
        check_held(1'b1);
        @(posedge clk_i);
        ext_req   <= 1'b0;
        stop_mode <= 1'b0;
        wait_release(4'h1);
        $display("test external done");
    endtask

    task automatic pulse_wdt();
        @(posedge clk_i);
        wdt_ovf <= 1'b1;
        @(posedge clk_i);
        wdt_ovf <= 1'b0;
    endtask

    task automatic t_wdt();
        pulse_wdt();
        check_held(1'b0);
        wait_release(4'h2);
        pulse_wdt();
        cycles(150);
        pulse_wdt();
        check_held(1'b0);
        wait_release(4'h2);
        $display("test watchdog done");
    endtask

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_supply();
        t_ext();
        t_wdt();
        conclude();
    end
endmodule
